// ### shared/siu_pkg.sv
package siu_pkg;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 15;
	localparam int OP_LSB = 0;
	localparam int OP_W = 3;
	localparam int MODE_LSB = 4;
	localparam int MODE_W = 2;
	localparam int SIGN_BIT = 15;

	typedef enum logic [1:0] {
		MODE_DIRECT = 2'h0,
		MODE_INDEXED = 2'h1,
		MODE_POP = 2'h2,
		MODE_PUSH = 2'h3
	} siu_mode_t;

	typedef enum logic [2:0] {
		OP_ADD = 3'h0,
		OP_ELEMENT_MINUS = 3'h1,
		OP_COMPARE_SKIP = 3'h2,
		OP_INCREMENT_SKIP = 3'h3,
		OP_JUMP_TO_ELEMENT = 3'h4,
		OP_CALL_VIA_ELEMENT = 3'h5,
		OP_POINTER_TO_ACC = 3'h6,
		OP_UNUSED = 3'h7
	} siu_op_t;

	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [15:0] ONE_WORD = 16'h0001;
	localparam logic [15:0] INSTR_LEN = 16'h0002;
	localparam logic [15:0] SKIP_ONE = 16'h0001;
	localparam logic [15:0] SKIP_TWO = 16'h0002;
	localparam logic [14:0] ONE_ADDR = 15'h0001;
endpackage

// ### core/siu_alu.sv
`timescale 1ns/1ns
`default_nettype none
module siu_alu (
	// Operands
	input  wire logic [15:0] acc,
	input  wire logic [15:0] elem,
	// Results
	output logic      [15:0] sum,
	output logic      [15:0] diff,
	output logic      [15:0] inc,
	output logic             add_ovf,
	output logic             sub_ovf,
	output logic             inc_ovf,
	output logic             acc_gt,
	output logic             acc_eq
);
	assign sum = acc + elem;
	assign diff = acc - elem;
	assign inc = elem + siu_pkg::ONE_WORD;
	// Signed overflow from operand and result signs
	assign add_ovf = (acc[15] == elem[15]) && (sum[15] != acc[15]);
	assign sub_ovf = (acc[15] != elem[15]) && (diff[15] != acc[15]);
	assign inc_ovf = !elem[15] && inc[15];
	assign acc_gt = $signed(acc) > $signed(elem);
	assign acc_eq = acc == elem;
endmodule
`default_nettype wire

// ### core/siu_top.sv
// How it works
// - Two-word instruction: opcode, pointer location
// - Four address modes chosen by mode field
// - Direct: fetched pointer is element address
// - Indexed: pointer plus X, bit 15 cleared
// - X zero selects newest, one older
// - Pop: access, then increment, write back
// - Push: decrement, write back, then access
// - Compare: greater skips one, equal two
// - Increment element, skip on zero, flag overflow
// - Jump loads PC with element address
// - Call stores PC+2, jumps element+1
// - Pointer value copied into A
// - Add element to A, flag overflow
// - Subtract element from A, flag overflow
// - Pointer is a 15-bit address
// - No indirection; top bit ignored
`timescale 1ns/1ns
`default_nettype none
module siu_top (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Processor side
	input  wire logic        start,
	input  wire logic [15:0] opcode_word,
	input  wire logic [15:0] pc_in,
	input  wire logic [15:0] a_in,
	input  wire logic [15:0] x_in,
	input  wire logic        ov_in,
	output logic             busy,
	output logic             done,
	output logic      [15:0] a_out,
	output logic      [15:0] pc_out,
	output logic             arith_excess_flag,
	// Main memory
	output logic             mem_req,
	output logic             mem_we,
	output logic      [14:0] mem_addr,
	output logic      [15:0] mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [15:0] mem_rdata
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_FETCH_LOC = 3'h1,
		ST_READ_PTR = 3'h2,
		ST_WRITE_PRE = 3'h3,
		ST_ACCESS_EL = 3'h4,
		ST_WRITE_EL = 3'h5,
		ST_WRITE_POST = 3'h6,
		ST_FINISH = 3'h7
	} siu_state_t;

	siu_state_t                state_r;
	siu_state_t                state_nxt;
	siu_pkg::siu_op_t          op_r;
	siu_pkg::siu_mode_t        mode_r;
	logic               [15:0] pc_r;
	logic               [15:0] x_r;
	logic               [15:0] a_r;
	logic                      ov_r;
	logic               [14:0] loc_r;
	logic               [15:0] ptr_r;
	logic               [15:0] elem_r;
	logic               [15:0] pc_res_r;

	logic               [15:0] sum;
	logic               [15:0] diff;
	logic               [15:0] inc;
	logic                      add_ovf;
	logic                      sub_ovf;
	logic                      inc_ovf;
	logic                      acc_gt;
	logic                      acc_eq;

	logic               [15:0] idx_sum;
	logic               [14:0] elem_addr;
	logic               [14:0] elem_addr_p1;
	logic               [15:0] ptr_dec;
	logic               [15:0] ptr_inc;
	logic               [15:0] pc_next_seq;
	logic                      op_reads;
	logic                      op_writes;
	logic                      op_touches;
	logic                      is_pop;
	logic                      is_push;
	logic               [3:0]  decoded_op;
	logic               [15:0] cmp_pc;

	siu_alu u_alu (
		.acc     (a_r),
		.elem    (mem_rdata),
		.sum     (sum),
		.diff    (diff),
		.inc     (inc),
		.add_ovf (add_ovf),
		.sub_ovf (sub_ovf),
		.inc_ovf (inc_ovf),
		.acc_gt  (acc_gt),
		.acc_eq  (acc_eq)
	);

	// Address formation
	assign is_pop = mode_r == siu_pkg::MODE_POP;
	assign is_push = mode_r == siu_pkg::MODE_PUSH;
	assign idx_sum = ptr_r + x_r;
	// Top bit never makes an indirect reference
	assign elem_addr = (mode_r == siu_pkg::MODE_INDEXED) ? idx_sum[14:0] : ptr_r[14:0];
	assign elem_addr_p1 = elem_addr + siu_pkg::ONE_ADDR;
	// Pointer arithmetic wraps within 15 bits, top bit kept
	assign ptr_dec = {ptr_r[15], ptr_r[14:0] - siu_pkg::ONE_ADDR};
	assign ptr_inc = {ptr_r[15], ptr_r[14:0] + siu_pkg::ONE_ADDR};
	assign pc_next_seq = pc_r + siu_pkg::INSTR_LEN;
	assign cmp_pc = acc_eq ? pc_next_seq + siu_pkg::SKIP_TWO
		: (acc_gt ? pc_next_seq + siu_pkg::SKIP_ONE : pc_next_seq);

	assign op_reads = (op_r == siu_pkg::OP_ADD) || (op_r == siu_pkg::OP_ELEMENT_MINUS)
		|| (op_r == siu_pkg::OP_COMPARE_SKIP) || (op_r == siu_pkg::OP_INCREMENT_SKIP);
	assign op_writes = op_r == siu_pkg::OP_CALL_VIA_ELEMENT;
	assign op_touches = op_reads || op_writes;
	assign decoded_op = {1'b0, opcode_word[siu_pkg::OP_LSB +: siu_pkg::OP_W]};

	// Memory port
	assign mem_req = (state_r != ST_IDLE) && (state_r != ST_FINISH);
	assign mem_we = (state_r == ST_WRITE_PRE) || (state_r == ST_WRITE_EL)
		|| (state_r == ST_WRITE_POST) || ((state_r == ST_ACCESS_EL) && op_writes);
	always_comb begin
		mem_addr = elem_addr;
		mem_wdata = elem_r;
		unique case (state_r)
			ST_IDLE, ST_FINISH: begin
				mem_addr = 15'h0000;
				mem_wdata = siu_pkg::RESET_WORD;
			end
			ST_FETCH_LOC: begin
				mem_addr = pc_r[14:0] + siu_pkg::ONE_ADDR;
			end
			ST_READ_PTR: begin
				mem_addr = loc_r;
			end
			ST_WRITE_PRE, ST_WRITE_POST: begin
				mem_addr = loc_r;
				mem_wdata = (state_r == ST_WRITE_PRE) ? ptr_r : ptr_inc;
			end
			ST_ACCESS_EL: begin
				mem_wdata = pc_next_seq;
			end
			ST_WRITE_EL: begin
				mem_wdata = elem_r;
			end
		endcase
	end

	// Sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (start) begin
					state_nxt = ST_FETCH_LOC;
				end
			end
			ST_FETCH_LOC: begin
				if (mem_ack) begin
					state_nxt = ST_READ_PTR;
				end
			end
			ST_READ_PTR: begin
				if (mem_ack) begin
					if (is_push) begin
						state_nxt = ST_WRITE_PRE;
					end else if (op_touches) begin
						state_nxt = ST_ACCESS_EL;
					end else if (is_pop) begin
						state_nxt = ST_WRITE_POST;
					end else begin
						state_nxt = ST_FINISH;
					end
				end
			end
			ST_WRITE_PRE: begin
				if (mem_ack) begin
					state_nxt = op_touches ? ST_ACCESS_EL : ST_FINISH;
				end
			end
			ST_ACCESS_EL: begin
				if (mem_ack) begin
					if (op_r == siu_pkg::OP_INCREMENT_SKIP) begin
						state_nxt = ST_WRITE_EL;
					end else begin
						state_nxt = is_pop ? ST_WRITE_POST : ST_FINISH;
					end
				end
			end
			ST_WRITE_EL: begin
				if (mem_ack) begin
					state_nxt = is_pop ? ST_WRITE_POST : ST_FINISH;
				end
			end
			ST_WRITE_POST: begin
				if (mem_ack) begin
					state_nxt = ST_FINISH;
				end
			end
			ST_FINISH: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Datapath
	always_ff @(posedge core_clk) begin
		if (reset) begin
			op_r <= siu_pkg::OP_ADD;
			mode_r <= siu_pkg::MODE_DIRECT;
			pc_r <= siu_pkg::RESET_WORD;
			x_r <= siu_pkg::RESET_WORD;
			a_r <= siu_pkg::RESET_WORD;
			ov_r <= 1'b0;
			loc_r <= 15'h0000;
			ptr_r <= siu_pkg::RESET_WORD;
			elem_r <= siu_pkg::RESET_WORD;
			pc_res_r <= siu_pkg::RESET_WORD;
		end else if (state_r == ST_IDLE) begin
			if (start) begin
				op_r <= siu_pkg::siu_op_t'(decoded_op[2:0]);
				mode_r <= siu_pkg::siu_mode_t'(opcode_word[siu_pkg::MODE_LSB +: siu_pkg::MODE_W]);
				pc_r <= pc_in;
				x_r <= x_in;
				a_r <= a_in;
				ov_r <= ov_in;
				pc_res_r <= pc_in + siu_pkg::INSTR_LEN;
			end
		end else if (mem_ack) begin
			unique case (state_r)
				ST_FETCH_LOC: begin
					loc_r <= mem_rdata[14:0];
				end
				ST_READ_PTR: begin
					ptr_r <= mem_mode_ptr(mem_rdata);
					if (op_r == siu_pkg::OP_POINTER_TO_ACC) begin
						a_r <= mem_mode_ptr(mem_rdata);
					end
					if (op_r == siu_pkg::OP_JUMP_TO_ELEMENT) begin
						pc_res_r <= jump_target(mem_rdata);
					end
				end
				ST_ACCESS_EL: begin
					unique case (op_r)
						siu_pkg::OP_ADD: begin
							a_r <= sum;
							ov_r <= ov_r | add_ovf;
						end
						siu_pkg::OP_ELEMENT_MINUS: begin
							a_r <= diff;
							ov_r <= ov_r | sub_ovf;
						end
						siu_pkg::OP_COMPARE_SKIP: begin
							pc_res_r <= cmp_pc;
						end
						siu_pkg::OP_INCREMENT_SKIP: begin
							elem_r <= inc;
							ov_r <= ov_r | inc_ovf;
							if (inc == siu_pkg::RESET_WORD) begin
								pc_res_r <= pc_next_seq + siu_pkg::SKIP_ONE;
							end
						end
						siu_pkg::OP_CALL_VIA_ELEMENT: begin
							pc_res_r <= {1'b0, elem_addr_p1};
						end
						default: begin
						end
					endcase
				end
				default: begin
				end
			endcase
		end
	end

	// Push mode shows the decremented pointer to every later step
	function automatic logic [15:0] mem_mode_ptr(input logic [15:0] word);
		logic [15:0] dec;
		dec = {word[15], word[14:0] - siu_pkg::ONE_ADDR};
		mem_mode_ptr = (mode_r == siu_pkg::MODE_PUSH) ? dec : word;
	endfunction

	function automatic logic [15:0] jump_target(input logic [15:0] word);
		logic [15:0] p;
		logic [15:0] s;
		p = mem_mode_ptr(word);
		s = p + x_r;
		jump_target = (mode_r == siu_pkg::MODE_INDEXED) ? {1'b0, s[14:0]} : {1'b0, p[14:0]};
	endfunction

	// Results to the processor
	always_ff @(posedge core_clk) begin
		if (reset) begin
			a_out <= siu_pkg::RESET_WORD;
			pc_out <= siu_pkg::RESET_WORD;
			arith_excess_flag <= 1'b0;
		end else if (state_r == ST_FINISH) begin
			a_out <= a_r;
			pc_out <= pc_res_r;
			arith_excess_flag <= ov_r;
		end
	end

	assign busy = state_r != ST_IDLE;
	assign done = state_r == ST_FINISH;
	logic unused_ok;
	assign unused_ok = ^{ptr_dec, decoded_op[3]};
endmodule
`default_nettype wire

// ### sim/siu_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module siu_mon (
	// Clock, reset and processor side
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        start,
	input wire logic [15:0] opcode_word,
	input wire logic [15:0] pc_in,
	input wire logic        ov_in,
	input wire logic        busy,
	input wire logic        done,
	input wire logic [15:0] a_out,
	input wire logic [15:0] pc_out,
	input wire logic        arith_excess_flag,
	// Memory side
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [14:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic        mem_ack,
	input wire logic [15:0] mem_rdata
);
	logic [2:0]  op_r;
	logic [1:0]  md_r;
	logic [2:0]  n_r;
	logic [15:0] pc_r;
	logic [15:0] rd_r;
	logic        ov_r;
	logic        wr_r;
	wire         go  = start && !busy;
	wire         acc = mem_req && mem_ack;
	// Instruction capture and count of completed accesses
	always_ff @(posedge core_clk) begin
		if (go) begin
			op_r <= opcode_word[2:0];
			md_r <= opcode_word[5:4];
			pc_r <= pc_in;
			ov_r <= ov_in;
		end
		n_r <= go ? 3'h0 : n_r + {2'h0, acc};
		if (acc)
			wr_r <= mem_we;
		if (acc && !mem_we)
			rd_r <= mem_rdata;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_first_fetch: assert property (go |=> mem_req && !mem_we && mem_addr == pc_r[14:0] + 15'h1)
		else $error("bad pointer location fetch");
	a_done_bound: assert property (go |-> ##[4:60] done)
		else $error("no completion");
	a_busy_taken: assert property (go |=> busy && !done)
		else $error("busy not raised after start");
	a_out_hold: assert property (!$past(reset) && !$past(done) |-> $stable(a_out) && $stable(pc_out))
		else $error("results moved outside completion");
	a_flag_keep: assert property (done && ov_r |=> arith_excess_flag)
		else $error("overflow flag lost");
	a_direct_addr: assert property (mem_req && md_r == siu_pkg::MODE_DIRECT && n_r == 3'h2 && op_r <= 3'h3 |-> !mem_we && mem_addr == rd_r[14:0])
		else $error("direct element address wrong");
	a_push_dec: assert property (mem_req && md_r == siu_pkg::MODE_PUSH && n_r == 3'h2 |-> mem_we && mem_wdata == rd_r - 16'h1)
		else $error("push write-back wrong");
	a_inc_store: assert property (mem_req && op_r == siu_pkg::OP_INCREMENT_SKIP && n_r == (md_r == siu_pkg::MODE_PUSH ? 3'h4 : 3'h3) |-> mem_we && mem_wdata == rd_r + 16'h1)
		else $error("incremented element wrong");
	a_call_store: assert property (mem_req && op_r == siu_pkg::OP_CALL_VIA_ELEMENT && n_r == (md_r == siu_pkg::MODE_PUSH ? 3'h3 : 3'h2) |-> mem_we && mem_wdata == pc_r + 16'h2)
		else $error("return address wrong");
	a_pop_wback: assert property (done && md_r == siu_pkg::MODE_POP |-> wr_r)
		else $error("pop without write-back");
endmodule
bind siu_top siu_mon i_siu_mon (.*);
`default_nettype wire

// ### sim/siu_mem.sv
`timescale 1ns/1ns
`default_nettype none
module siu_mem (
	input wire logic        core_clk,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [14:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic            mem_ack,
	output logic     [15:0] mem_rdata,
	// Wait cycles before each acknowledge
	input wire logic [1:0]  slow
);
	logic [15:0] m [32768];
	logic [1:0]  w_r = 2'h0;
	assign mem_ack = mem_req && w_r == slow;
	// Released data bus shows the inverse, never a stale word
	assign mem_rdata = mem_ack ? m[mem_addr] : ~m[mem_addr];
	always @(posedge core_clk) begin
		w_r <= (mem_req && !mem_ack) ? w_r + 2'h1 : 2'h0;
		if (mem_ack && mem_we)
			m[mem_addr] <= mem_wdata;
	end
endmodule
`default_nettype wire

// ### sim/siu_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module siu_top_tb;
	logic        core_clk, reset, start, ov_in, busy, done, arith_excess_flag;
	logic        mem_req, mem_we, mem_ack;
	logic [15:0] opcode_word, pc_in, a_in, x_in, a_out, pc_out, mem_wdata, mem_rdata;
	logic [14:0] mem_addr;
	logic [1:0]  slow;
	int          n_mismatch, num_checks, cyc;
	siu_top i_siu_top (.*);
	siu_mem i_siu_mem (.*);
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic prep(input logic [15:0] pc, loc, ptr, el);
		i_siu_mem.m[pc[14:0] + 15'h1] = loc;
		i_siu_mem.m[loc[14:0]] = ptr;
		i_siu_mem.m[ptr[14:0]] = el;
	endtask
	task automatic exec(input siu_pkg::siu_op_t op, input siu_pkg::siu_mode_t md,
			input logic [15:0] pc, a, x, input logic ov);
		int n;
		opcode_word = {10'h0, md, 1'b0, op};
		pc_in = pc;
		a_in = a;
		x_in = x;
		ov_in = ov;
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		// A hung instruction counts against the run
		if (n >= 100) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, 16'h0000, 16'h0001);
		end
		@(negedge core_clk);
	endtask
	task automatic t_add();
		prep(16'h0010, 16'h0040, 16'h0050, 16'h0001);
		exec(siu_pkg::OP_ADD, siu_pkg::MODE_DIRECT, 16'h0010, 16'h7fff, 16'h0, 1'b0);
		chk(a_out, 16'h8000);
		chk(pc_out, 16'h0012);
		chk({15'h0, arith_excess_flag}, 16'h0001);
	endtask
	task automatic t_idx();
		prep(16'h0020, 16'h0060, 16'h0100, 16'h0009);
		i_siu_mem.m[15'h0101] = 16'h0001;
		i_siu_mem.m[15'h0000] = 16'h0004;
		exec(siu_pkg::OP_ELEMENT_MINUS, siu_pkg::MODE_INDEXED, 16'h0020, 16'h0005, 16'h0, 1'b0);
		chk(a_out, 16'hfffc);
		chk({15'h0, arith_excess_flag}, 16'h0000);
		exec(siu_pkg::OP_ELEMENT_MINUS, siu_pkg::MODE_INDEXED, 16'h0020, 16'h8000, 16'h1, 1'b0);
		chk(a_out, 16'h7fff);
		chk({15'h0, arith_excess_flag}, 16'h0001);
		i_siu_mem.m[15'h0060] = 16'h7fff;
		exec(siu_pkg::OP_ELEMENT_MINUS, siu_pkg::MODE_INDEXED, 16'h0020, 16'h0005, 16'h1, 1'b1);
		chk(a_out, 16'h0001);
	endtask
	task automatic t_cmp();
		logic [15:0] av [3] = '{16'h0002, 16'h0001, 16'hffff};
		logic [15:0] pe [3] = '{16'h0043, 16'h0044, 16'h0042};
		prep(16'h0040, 16'h0080, 16'h0090, 16'h0001);
		for (int i = 0; i < 3; i++) begin
			exec(siu_pkg::OP_COMPARE_SKIP, siu_pkg::MODE_DIRECT, 16'h0040, av[i], 16'h0, 1'b0);
			chk(pc_out, pe[i]);
		end
	endtask
	task automatic t_inc();
		slow = 2'h2;
		prep(16'h00a0, 16'h00b0, 16'h0200, 16'h0);
		i_siu_mem.m[15'h01ff] = 16'hffff;
		i_siu_mem.m[15'h01fe] = 16'h7fff;
		exec(siu_pkg::OP_INCREMENT_SKIP, siu_pkg::MODE_PUSH, 16'h00a0, 16'h0, 16'h0, 1'b0);
		chk(i_siu_mem.m[15'h00b0], 16'h01ff);
		chk(i_siu_mem.m[15'h01ff], 16'h0000);
		chk(pc_out, 16'h00a3);
		exec(siu_pkg::OP_INCREMENT_SKIP, siu_pkg::MODE_PUSH, 16'h00a0, 16'h0, 16'h0, 1'b0);
		chk(pc_out, 16'h00a2);
		chk({15'h0, arith_excess_flag}, 16'h0001);
		slow = 2'h0;
	endtask
	task automatic t_pop();
		prep(16'h00c0, 16'h00d0, 16'h0300, 16'h0001);
		exec(siu_pkg::OP_ADD, siu_pkg::MODE_POP, 16'h00c0, 16'h0002, 16'h0, 1'b0);
		chk(a_out, 16'h0003);
		chk(i_siu_mem.m[15'h00d0], 16'h0301);
	endtask
	task automatic t_jmp();
		prep(16'h00e0, 16'h00f0, 16'h0400, 16'h0);
		exec(siu_pkg::OP_JUMP_TO_ELEMENT, siu_pkg::MODE_DIRECT, 16'h00e0, 16'h0, 16'h0, 1'b0);
		chk(pc_out, 16'h0400);
		exec(siu_pkg::OP_CALL_VIA_ELEMENT, siu_pkg::MODE_DIRECT, 16'h00e0, 16'h0, 16'h0, 1'b0);
		chk(i_siu_mem.m[15'h0400], 16'h00e2);
		chk(pc_out, 16'h0401);
	endtask
	task automatic t_ptr();
		prep(16'h0110, 16'h0120, 16'h8600, 16'h0005);
		exec(siu_pkg::OP_POINTER_TO_ACC, siu_pkg::MODE_DIRECT, 16'h0110, 16'h0, 16'h0, 1'b0);
		chk(a_out, 16'h8600);
		exec(siu_pkg::OP_ADD, siu_pkg::MODE_DIRECT, 16'h0110, 16'h0001, 16'h0, 1'b0);
		chk(a_out, 16'h0006);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			test_done();
		end
	end
	initial begin
		{reset, start, ov_in, slow} = {1'b1, 3'h0, 2'h0};
		{opcode_word, pc_in, a_in, x_in} = 64'h0;
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		reset = 1'b0;
		t_add();
		t_idx();
		t_cmp();
		t_inc();
		t_pop();
		t_jmp();
		t_ptr();
		test_done();
	end
endmodule
`default_nettype wire
